/* File: lamc_top.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module lamc_top #(
  parameter int unsigned TICK_CYCLES = lamc_pkg::PD_TICK_CYCLES
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [7:0]                      awaddr,
  input  wire logic [2:0]                      awprot,
  input  wire logic                            awvalid,
  output var  logic                            awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output var  logic                            wready,
  output var  logic [1:0]                      bresp,
  output var  logic                            bvalid,
  input  wire logic                            bready,
  input  wire logic [7:0]                      araddr,
  input  wire logic [2:0]                      arprot,
  input  wire logic                            arvalid,
  output var  logic                            arready,
  output var  logic [31:0]                     rdata,
  output var  logic [1:0]                      rresp,
  output var  logic                            rvalid,
  input  wire logic                            rready,
  input  wire logic [lamc_pkg::SPEED_W-1:0]    speed,
  input  wire lamc_pkg::lamc_load_t            load,
  output var  logic [lamc_pkg::LEVEL_W-1:0]    coil_level,
  output var  logic                            motor_halt,
  output var  logic                            irq
);

  //////////////////////////////////////////////////////////////////////////
  // state
  lamc_pkg::lamc_cfg_t  cfg_q, cfg_d;
  lamc_pkg::lamc_mode_t mode_q, mode_d;
  logic [4:0]  cur_q, cur_d;
  logic [5:0]  dn_cnt_q, dn_cnt_d;
  logic [19:0] tick_q, tick_d;
  logic [15:0] pd_cnt_q, pd_cnt_d;
  logic        halt_q, halt_d;
  logic [lamc_pkg::IRQ_W-1:0] istat_q, istat_d, imask_q, imask_d;
  logic        irq_q, irq_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]  waddr_q, waddr_d;
  logic [31:0] wdat_q, wdat_d;
  logic [3:0]  wstb_q, wstb_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // combinational helpers
  logic [4:0]  cs_lvl, sb_lvl, min_lvl, up_step;
  logic [5:0]  dn_size, up_sum;
  logic [10:0] upper;
  logic        below, above, standstill, pd_done, stall_ev, do_write, rel;
  logic [31:0] wv, rv;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (stb[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // current scale, thresholds, mode
  always_comb
  begin
    cs_lvl  = cfg_q.abs_max[7:3];
    sb_lvl  = cfg_q.standby[7:3];
    min_lvl = cfg_q.min_sel ? (cs_lvl >> 2) : (cs_lvl >> 1);
    up_step = 5'h01 << cfg_q.up_code;
    case (cfg_q.down_code)
      2'h0:    dn_size = 6'h20;
      2'h1:    dn_size = 6'h08;
      2'h2:    dn_size = 6'h02;
      default: dn_size = 6'h01;
    endcase
    upper      = {1'b0, cfg_q.lower} + {1'b0, cfg_q.hyst};
    below      = load.valid && (load.value < cfg_q.lower);
    above      = load.valid && ({1'b0, load.value} > upper);
    standstill = (speed == '0);
    tick_d     = tick_q;
    pd_cnt_d   = pd_cnt_q;
    if (!standstill)
    begin
      tick_d   = '0;
      pd_cnt_d = '0;
    end
    else if (tick_q == 20'(TICK_CYCLES - 1))
    begin
      tick_d = '0;
      if (pd_cnt_q != 16'hffff)
      begin
        pd_cnt_d = pd_cnt_q + 16'h0001;
      end
    end
    else
    begin
      tick_d = tick_q + 20'h00001;
    end
    pd_done = standstill && (pd_cnt_q >= cfg_q.pd_delay);
    if (pd_done)
    begin
      mode_d = lamc_pkg::MODE_STANDBY;
    end
    else if (speed > cfg_q.reg_speed)
    begin
      mode_d = lamc_pkg::MODE_REGULATE;
    end
    else
    begin
      mode_d = lamc_pkg::MODE_NORMAL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // coil current regulation
  always_comb
  begin
    up_sum   = {1'b0, cur_q} + {1'b0, up_step};
    cur_d    = cur_q;
    dn_cnt_d = dn_cnt_q;
    case (mode_d)
      lamc_pkg::MODE_STANDBY:
      begin
        cur_d    = sb_lvl;
        dn_cnt_d = '0;
      end
      lamc_pkg::MODE_REGULATE:
      begin
        if (mode_q != lamc_pkg::MODE_REGULATE)
        begin
          cur_d    = cs_lvl;
          dn_cnt_d = '0;
        end
        else if (below)
        begin
          cur_d    = (up_sum > {1'b0, cs_lvl}) ? cs_lvl : up_sum[4:0];
          dn_cnt_d = '0;
        end
        else if (above)
        begin
          if (dn_cnt_q + 6'h01 >= dn_size)
          begin
            dn_cnt_d = '0;
            cur_d    = (cur_q > min_lvl) ? cur_q - 5'h01 : min_lvl;
          end
          else
          begin
            dn_cnt_d = dn_cnt_q + 6'h01;
          end
        end
        else if (load.valid)
        begin
          dn_cnt_d = '0;
        end
        if (cur_d > cs_lvl)
        begin
          cur_d = cs_lvl;
        end
        else if (cur_d < min_lvl)
        begin
          cur_d = min_lvl;
        end
      end
      default:
      begin
        cur_d    = cs_lvl;
        dn_cnt_d = '0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, stall stop, interrupts
  always_comb
  begin
    do_write  = aw_got_q && w_got_q && !bvalid_q;
    aw_got_d  = do_write ? 1'b0 : (aw_got_q || (awvalid && awready_q));
    w_got_d   = do_write ? 1'b0 : (w_got_q || (wvalid && wready_q));
    waddr_d   = (awvalid && awready_q) ? awaddr : waddr_q;
    wdat_d    = (wvalid && wready_q) ? wdata : wdat_q;
    wstb_d    = (wvalid && wready_q) ? wstrb : wstb_q;
    bvalid_d  = do_write ? 1'b1 : (bvalid_q && !bready);
    bresp_d   = bresp_q;
    awready_d = !aw_got_d && !bvalid_d;
    wready_d  = !w_got_d && !bvalid_d;
    cfg_d     = cfg_q;
    imask_d   = imask_q;
    rel       = 1'b0;
    wv        = '0;
    if (do_write)
    begin
      bresp_d = lamc_pkg::RESP_OKAY;
      case (waddr_q)
        lamc_pkg::OFS_CUR_CFG:
        begin
          wv = merge({11'h000, cfg_q.up_code, cfg_q.down_code, cfg_q.min_sel,
                      cfg_q.standby, cfg_q.abs_max}, wdat_q, wstb_q);
          cfg_d.abs_max   = wv[lamc_pkg::ABS_MAX_LSB +: 8];
          cfg_d.standby   = wv[lamc_pkg::STANDBY_LSB +: 8];
          cfg_d.min_sel   = wv[lamc_pkg::MIN_SEL_BIT];
          cfg_d.down_code = wv[lamc_pkg::DOWN_LSB +: 2];
          cfg_d.up_code   = wv[lamc_pkg::UP_LSB +: 2];
        end
        lamc_pkg::OFS_LOAD_CFG:
        begin
          wv = merge({6'h00, cfg_q.hyst, 6'h00, cfg_q.lower}, wdat_q, wstb_q);
          cfg_d.lower = wv[lamc_pkg::LOWER_LSB +: lamc_pkg::LOAD_W];
          cfg_d.hyst  = wv[lamc_pkg::HYST_LSB +: lamc_pkg::LOAD_W];
        end
        lamc_pkg::OFS_STALL_SPD:
        begin
          wv = merge({8'h00, cfg_q.stall_speed}, wdat_q, wstb_q);
          cfg_d.stall_speed = wv[lamc_pkg::SPEED_W-1:0];
        end
        lamc_pkg::OFS_REG_SPD:
        begin
          wv = merge({8'h00, cfg_q.reg_speed}, wdat_q, wstb_q);
          cfg_d.reg_speed = wv[lamc_pkg::SPEED_W-1:0];
        end
        lamc_pkg::OFS_PD_DELAY:
        begin
          wv = merge({16'h0000, cfg_q.pd_delay}, wdat_q, wstb_q);
          cfg_d.pd_delay = wv[15:0];
        end
        lamc_pkg::OFS_IRQ_STAT:
        begin
          wv = merge(32'h00000000, wdat_q, wstb_q);
        end
        lamc_pkg::OFS_IRQ_MASK:
        begin
          wv = merge({30'h00000000, imask_q}, wdat_q, wstb_q);
          imask_d = wv[lamc_pkg::IRQ_W-1:0];
        end
        lamc_pkg::OFS_CMD:
        begin
          wv  = merge(32'h00000000, wdat_q, wstb_q);
          rel = wv[lamc_pkg::CMD_RELEASE];
        end
        lamc_pkg::OFS_STATUS:
        begin
          wv = '0;
        end
        default:
        begin
          bresp_d = lamc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // zero load marks stall; only above stall speed
    stall_ev = load.valid && (load.value == '0) && (speed > cfg_q.stall_speed);
    halt_d   = (halt_q && !rel) || stall_ev;
    istat_d  = istat_q;
    if (do_write && (waddr_q == lamc_pkg::OFS_IRQ_STAT))
    begin
      istat_d = istat_q & ~wv[lamc_pkg::IRQ_W-1:0];
    end
    istat_d[lamc_pkg::IRQ_STALL]   = istat_d[lamc_pkg::IRQ_STALL] | stall_ev;
    istat_d[lamc_pkg::IRQ_STANDBY] = istat_d[lamc_pkg::IRQ_STANDBY] |
      ((mode_d == lamc_pkg::MODE_STANDBY) && (mode_q != lamc_pkg::MODE_STANDBY));
    irq_d = |(istat_d & imask_d);
    rvalid_d  = (arvalid && arready_q) ? 1'b1 : (rvalid_q && !rready);
    arready_d = !rvalid_d;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    rv        = '0;
    if (arvalid && arready_q)
    begin
      rresp_d = lamc_pkg::RESP_OKAY;
      case (araddr)
        lamc_pkg::OFS_CUR_CFG:   rv = {11'h000, cfg_q.up_code, cfg_q.down_code,
                                       cfg_q.min_sel, cfg_q.standby, cfg_q.abs_max};
        lamc_pkg::OFS_LOAD_CFG:  rv = {6'h00, cfg_q.hyst, 6'h00, cfg_q.lower};
        lamc_pkg::OFS_STALL_SPD: rv = {8'h00, cfg_q.stall_speed};
        lamc_pkg::OFS_REG_SPD:   rv = {8'h00, cfg_q.reg_speed};
        lamc_pkg::OFS_PD_DELAY:  rv = {16'h0000, cfg_q.pd_delay};
        lamc_pkg::OFS_STATUS:    rv = {20'h00000, halt_q, mode_q, 3'h0, cur_q};
        lamc_pkg::OFS_IRQ_STAT:  rv = {30'h00000000, istat_q};
        lamc_pkg::OFS_IRQ_MASK:  rv = {30'h00000000, imask_q};
        lamc_pkg::OFS_CMD:       rv = '0;
        default:                 rresp_d = lamc_pkg::RESP_SLVERR;
      endcase
      rdata_d = rv;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q     <= '{abs_max: lamc_pkg::ABS_MAX_RST, standby: lamc_pkg::STANDBY_RST,
                     pd_delay: lamc_pkg::PD_DELAY_RST, default: '0};
      mode_q    <= lamc_pkg::MODE_NORMAL;
      cur_q     <= lamc_pkg::ABS_MAX_RST[7:3];
      dn_cnt_q  <= '0;
      tick_q    <= '0;
      pd_cnt_q  <= '0;
      halt_q    <= 1'b0;
      istat_q   <= '0;
      imask_q   <= '0;
      irq_q     <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      waddr_q   <= '0;
      wdat_q    <= '0;
      wstb_q    <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= lamc_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= lamc_pkg::RESP_OKAY;
      rdata_q   <= '0;
    end
    else
    begin
      cfg_q     <= cfg_d;
      mode_q    <= mode_d;
      cur_q     <= cur_d;
      dn_cnt_q  <= dn_cnt_d;
      tick_q    <= tick_d;
      pd_cnt_q  <= pd_cnt_d;
      halt_q    <= halt_d;
      istat_q   <= istat_d;
      imask_q   <= imask_d;
      irq_q     <= irq_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      waddr_q   <= waddr_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  always_comb
  begin
    awready    = awready_q;
    wready     = wready_q;
    bvalid     = bvalid_q;
    bresp      = bresp_q;
    arready    = arready_q;
    rvalid     = rvalid_q;
    rresp      = rresp_q;
    rdata      = rdata_q;
    coil_level = cur_q;
    motor_halt = halt_q;
    irq        = irq_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  // reference values recomputed from the configuration and the current coil level
  logic [5:0] up_goal;
  logic [4:0] cap_lvl;

  assign up_goal = {1'b0, cur_q} + (6'h01 << cfg_q.up_code);
  assign cap_lvl = cfg_q.abs_max[7:3];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cur_ceiling: assert property
    (cur_q <= $past(cs_lvl) || mode_q == lamc_pkg::MODE_STANDBY)
    else $error("coil level above maximum");
  a_cur_floor: assert property
    (mode_q == lamc_pkg::MODE_REGULATE |-> cur_q >= $past(min_lvl))
    else $error("coil level below minimum");
  a_min_fraction: assert property
    (mode_q == lamc_pkg::MODE_REGULATE |-> cur_q >= ($past(cfg_q.min_sel) ?
     ($past(cap_lvl) >> 2) : ($past(cap_lvl) >> 1)))
    else $error("coil level below minimum fraction");
  a_standby_lvl: assert property
    (mode_q == lamc_pkg::MODE_STANDBY |-> cur_q == $past(sb_lvl))
    else $error("standby level wrong");
  a_pd_delay: assert property
    (standstill && pd_cnt_q < cfg_q.pd_delay |=> mode_q != lamc_pkg::MODE_STANDBY)
    else $error("standby entered early");
  a_up_step: assert property
    (mode_q == lamc_pkg::MODE_REGULATE && mode_d == lamc_pkg::MODE_REGULATE && below
     |=> {1'b0, cur_q} == (($past(up_goal) > {1'b0, $past(cap_lvl)}) ?
     {1'b0, $past(cap_lvl)} : $past(up_goal)))
    else $error("up step wrong");
  a_down_group: assert property
    (mode_q == lamc_pkg::MODE_REGULATE && mode_d == lamc_pkg::MODE_REGULATE && above
     && dn_cnt_q + 6'h01 < dn_size && cur_q >= min_lvl |=> cur_q == $past(cur_q))
    else $error("decrement before group complete");
  a_hyst_hold: assert property
    (mode_q == lamc_pkg::MODE_REGULATE && mode_d == lamc_pkg::MODE_REGULATE && load.valid
     && !below && !above && cur_q >= min_lvl |=> cur_q == $past(cur_q))
    else $error("current changed inside hysteresis");
  a_stall_stop: assert property
    (load.valid && load.value == '0 && speed > cfg_q.stall_speed |=> motor_halt)
    else $error("no halt on stall");
  a_no_stall_slow: assert property
    (!halt_q && !(load.valid && speed > cfg_q.stall_speed) |=> !motor_halt)
    else $error("halt below stall speed");
  a_normal_cur: assert property
    (mode_q == lamc_pkg::MODE_NORMAL |-> cur_q == $past(cs_lvl))
    else $error("normal mode not at full level");

endmodule // lamc_top

`default_nettype wire

/* File: lamc_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`default_nettype none

package lamc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned PD_TICK_MS     = 10;
  localparam int unsigned PD_TICK_CYCLES = PD_TICK_MS * 1000000 / CLK_PERIOD_NS;

  // widths
  localparam int unsigned LOAD_W  = 10;
  localparam int unsigned SPEED_W = 24;
  localparam int unsigned LEVEL_W = 5;

  // register byte offsets
  localparam logic [7:0] OFS_CUR_CFG   = 8'h00;
  localparam logic [7:0] OFS_LOAD_CFG  = 8'h04;
  localparam logic [7:0] OFS_STALL_SPD = 8'h08;
  localparam logic [7:0] OFS_REG_SPD   = 8'h0c;
  localparam logic [7:0] OFS_PD_DELAY  = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1c;
  localparam logic [7:0] OFS_CMD       = 8'h20;

  // field positions
  localparam int unsigned ABS_MAX_LSB  = 0;
  localparam int unsigned STANDBY_LSB  = 8;
  localparam int unsigned MIN_SEL_BIT  = 16;
  localparam int unsigned DOWN_LSB     = 17;
  localparam int unsigned UP_LSB       = 19;
  localparam int unsigned LOWER_LSB    = 0;
  localparam int unsigned HYST_LSB     = 16;
  localparam int unsigned ST_LEVEL_LSB = 0;
  localparam int unsigned ST_MODE_LSB  = 8;
  localparam int unsigned ST_HALT_BIT  = 11;
  localparam int unsigned IRQ_STALL    = 0;
  localparam int unsigned IRQ_STANDBY  = 1;
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned CMD_RELEASE  = 0;

  // reset values
  localparam logic [7:0]  ABS_MAX_RST  = 8'hff;
  localparam logic [7:0]  STANDBY_RST  = 8'h40;
  localparam logic [15:0] PD_DELAY_RST = 16'h00c8;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0]         abs_max;
    logic [7:0]         standby;
    logic               min_sel;
    logic [1:0]         down_code;
    logic [1:0]         up_code;
    logic [LOAD_W-1:0]  lower;
    logic [LOAD_W-1:0]  hyst;
    logic [SPEED_W-1:0] stall_speed;
    logic [SPEED_W-1:0] reg_speed;
    logic [15:0]        pd_delay;
  } lamc_cfg_t;

  typedef struct packed {
    logic              valid;
    logic [LOAD_W-1:0] value;
  } lamc_load_t;

  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b001,
    MODE_REGULATE = 3'b010,
    MODE_STANDBY  = 3'b100
  } lamc_mode_t;

endpackage

`default_nettype wire

/* File: lamc_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lamc_motor_model (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [lamc_pkg::SPEED_W-1:0] target_speed,
  input  wire logic [lamc_pkg::LOAD_W-1:0]  sample_value,
  input  wire logic                         sample_fire,
  input  wire logic                         motor_halt,
  output var  logic [lamc_pkg::SPEED_W-1:0] speed,
  output var  lamc_pkg::lamc_load_t         load
);

  // readings appear one cycle after the request; a halted rotor reads standstill
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      speed <= '0;
      load  <= '0;
    end
    else
    begin
      speed      <= motor_halt ? '0 : target_speed;
      load.valid <= sample_fire;
      // value line toggles between readings, never holds the last one
      load.value <= sample_fire ? sample_value : ~load.value;
    end
  end

endmodule // lamc_motor_model

`default_nettype wire

/* File: load_adaptive_motor_current_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module load_adaptive_motor_current_tb_top;

  logic                         aclk;
  logic                         aresetn = 1'b0;
  logic [7:0]                   awaddr  = 8'h00;
  logic [7:0]                   araddr  = 8'h00;
  logic [31:0]                  wdata   = 32'h0;
  logic                         awvalid = 1'b0;
  logic                         wvalid  = 1'b0;
  logic                         bready  = 1'b0;
  logic                         arvalid = 1'b0;
  logic                         rready  = 1'b0;
  logic                         fire    = 1'b0;
  logic [lamc_pkg::LOAD_W-1:0]  sval    = 10'h000;
  logic [lamc_pkg::SPEED_W-1:0] target  = 24'h000000;
  logic [lamc_pkg::SPEED_W-1:0] speed;
  logic                         awready, wready, bvalid, arready, rvalid, motor_halt, irq;
  logic [1:0]                   bresp, rresp;
  logic [31:0]                  rdata;
  logic [lamc_pkg::LEVEL_W-1:0] coil_level;
  lamc_pkg::lamc_load_t         load;
  int                           failures    = 0;
  int                           checks_done = 0;

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  lamc_top #(.TICK_CYCLES(10)) lamc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .speed(speed), .load(load), .coil_level(coil_level),
    .motor_halt(motor_halt), .irq(irq));

  lamc_motor_model lamc_motor_model_inst (
    .aclk(aclk), .aresetn(aresetn), .target_speed(target), .sample_value(sval),
    .sample_fire(fire), .motor_halt(motor_halt), .speed(speed), .load(load));

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic axi(input logic wr_op, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int   n;
    logic done;
    done = 1'b0;
    q = '0;
    r = '0;
    @(posedge aclk);
    if (wr_op)
    begin
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
    end
    else
    begin
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
    end
    for (n = 0; n < 100 && !done; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bready && bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
      if (rready && rvalid)
      begin
        q = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
    begin
      failures++;
      $display("wrong value at %0t: bus answer timed out", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = lamc_pkg::RESP_OKAY);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'b1, a, d, q, r);
    chk(32'(r), 32'(er), "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er = lamc_pkg::RESP_OKAY);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'b0, a, 32'h0, q, r);
    chk(32'(r), 32'(er), "read response");
    chk(q, ed, "read data");
  endtask

  // n back-to-back readings, then time for the level to settle
  task automatic feed(input logic [9:0] v, input int n);
    @(posedge aclk);
    sval <= v;
    fire <= 1'b1;
    repeat (n) @(posedge aclk);
    fire <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic lvl(input int e, input string m);
    chk(32'(coil_level), 32'(e), m);
  endtask

  function automatic logic [31:0] cur(input logic ms, input logic [1:0] dn, input logic [1:0] up);
    return {11'h000, up, dn, ms, 16'h40ff};
  endfunction

  task automatic step(input logic [31:0] cfg, input logic [9:0] v, input int n, input int e);
    wr(lamc_pkg::OFS_CUR_CFG, cfg);
    feed(v, n);
    lvl(e, "regulated level");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    lvl(31, "reset level");
    chk(32'(motor_halt), 32'h0, "reset halt");
    chk(32'(irq), 32'h0, "reset irq");
    rd(lamc_pkg::OFS_CUR_CFG, 32'h000040ff);
    rd(lamc_pkg::OFS_PD_DELAY, 32'h000000c8);
    rd(8'h40, 32'h0, lamc_pkg::RESP_SLVERR);
    wr(8'h44, 32'h1, lamc_pkg::RESP_SLVERR);
    @(posedge aclk);
    target <= 24'd100;
    $display("reset test done");
  endtask

  task automatic t_quant;
    wr(lamc_pkg::OFS_REG_SPD, 32'h000003e8);
    wr(lamc_pkg::OFS_LOAD_CFG, 32'h00320064);
    wr(lamc_pkg::OFS_CUR_CFG, 32'h000040a0);
    repeat (3) @(posedge aclk);
    lvl(20, "scale a0");
    wr(lamc_pkg::OFS_CUR_CFG, 32'h0000409f);
    repeat (3) @(posedge aclk);
    lvl(19, "scale 9f");
    feed(10'd10, 4);
    lvl(19, "no regulation at low speed");
    wr(lamc_pkg::OFS_CUR_CFG, cur(1'b0, 2'd0, 2'd0));
    $display("scale test done");
  endtask

  task automatic t_down;
    int g [4] = '{32, 8, 2, 1};
    wr(lamc_pkg::OFS_REG_SPD, 32'h00000032);
    repeat (3) @(posedge aclk);
    lvl(31, "regulation entry");
    for (int c = 0; c < 4; c++)
    begin
      wr(lamc_pkg::OFS_CUR_CFG, cur(1'b0, 2'(c), 2'd0));
      feed(10'd150, 1);
      if (g[c] > 1) feed(10'd200, g[c] - 1);
      lvl(31 - c, "group not complete");
      feed(10'd200, 1);
      lvl(30 - c, "group complete");
    end
    $display("down test done");
  endtask

  task automatic t_up;
    step(cur(1'b0, 2'd0, 2'd0), 10'd10, 1, 28);
    step(cur(1'b0, 2'd0, 2'd1), 10'd10, 1, 30);
    step(cur(1'b0, 2'd0, 2'd2), 10'd10, 1, 31);
    step(cur(1'b0, 2'd3, 2'd0), 10'd200, 20, 15);
    step(cur(1'b1, 2'd3, 2'd0), 10'd200, 10, 7);
    step(cur(1'b1, 2'd3, 2'd3), 10'd10, 1, 15);
    $display("up test done");
  endtask

  task automatic t_stall;
    wr(lamc_pkg::OFS_STALL_SPD, 32'h00000032);
    @(posedge aclk);
    target <= 24'd50;
    repeat (3) @(posedge aclk);
    feed(10'd0, 1);
    chk(32'(motor_halt), 32'h0, "no stop at limit speed");
    target <= 24'd51;
    repeat (3) @(posedge aclk);
    feed(10'd0, 1);
    chk(32'(motor_halt), 32'h1, "stop above limit");
    chk(32'(irq), 32'h0, "masked irq");
    wr(lamc_pkg::OFS_IRQ_MASK, 32'h00000003);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1, "unmasked irq");
    rd(lamc_pkg::OFS_IRQ_STAT, 32'h00000001);
    wr(lamc_pkg::OFS_CMD, 32'h00000001);
    repeat (2) @(posedge aclk);
    chk(32'(motor_halt), 32'h0, "halt released");
    wr(lamc_pkg::OFS_IRQ_STAT, 32'h00000001);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0, "irq cleared");
    $display("stall test done");
  endtask

  task automatic t_standby;
    int n;
    wr(lamc_pkg::OFS_PD_DELAY, 32'h00000003);
    @(posedge aclk);
    target <= 24'd0;
    repeat (15) @(posedge aclk);
    lvl(31, "before delay");
    for (n = 0; n < 60 && coil_level !== 5'd8; n++) @(posedge aclk);
    lvl(8, "standby level");
    chk(32'(irq), 32'h1, "standby irq");
    rd(lamc_pkg::OFS_STATUS, 32'h00000408);
    $display("standby test done");
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_quant();
    t_down();
    t_up();
    t_stall();
    t_standby();
    conclude();
  end

endmodule // load_adaptive_motor_current_tb_top

`default_nettype wire
